// ===== hdl/psc_pkg.sv
/*
 * Shared constants and types of the synthesizer control latches: word layout,
 * latch select codes, reset values, power-down states and timer scaling.
 * Assumes a 24-bit serial word with the latch select in its two low bits.
 */
package psc_pkg;

   localparam int PSC_WORD_W = 24;

   // latch select codes carried in the two low bits of every word
   localparam logic [1:0] PSC_SEL_REF  = 2'h0;
   localparam logic [1:0] PSC_SEL_AB   = 2'h1;
   localparam logic [1:0] PSC_SEL_FUNC = 2'h2;
   localparam logic [1:0] PSC_SEL_INIT = 2'h3;

   // pump boost bit position inside the AB counter word
   localparam int PSC_AB_GAIN_POS = 21;

   // pump events per step of the timeout select field
   localparam int PSC_FL_UNIT_EVENTS = 4;
   localparam int PSC_TMR_W          = 8;

   localparam logic [PSC_WORD_W-1:0] PSC_WORD_RESET = 24'h000000;
   localparam logic [1:0]            PSC_SYNC_RESET = 2'h0;
   localparam logic [PSC_TMR_W-1:0]  PSC_TMR_RESET  = 8'h00;

   // function and initialization latches share this layout
   typedef struct packed {
      logic [1:0] prescaler_ratio_select;
      logic       power_down_sync_select;
      logic [2:0] secondary_pump_current;
      logic [2:0] primary_pump_current;
      logic [3:0] fastlock_timeout_select;
      logic       fastlock_mode;
      logic       fastlock_enable;
      logic       pump_three_state;
      logic       pd_polarity;
      logic [2:0] monitor_mux_select;
      logic       power_down_request_bit;
      logic       counter_hold_bit;
      logic [1:0] latch_select_bits;
   } psc_func_type;

   localparam psc_func_type PSC_FUNC_RESET = psc_func_type'(24'h000000);

   // received word with its one-cycle valid strobe
   typedef struct packed {
      logic                  valid;
      logic [PSC_WORD_W-1:0] word;
   } psc_word_type;

   typedef enum logic [1:0] {
      PSC_RUN       = 2'b00,
      PSC_SYNC_WAIT = 2'b01,
      PSC_DOWN      = 2'b11
   } psc_pd_state_type;

endpackage

// ===== hdl/psc_serial_rx.sv
/*
 * Three-wire serial receiver: synchronises clock, data and load strobe,
 * shifts on serial clock rising edges, emits the word on load rising edge.
 * Assumes the serial clock is at least four system clocks per half period.
 */
`timescale 1ns/1ps
module psc_serial_rx
   import psc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ser_clk,
   input  wire logic         ser_data,
   input  wire logic         load_en,
   output psc_word_type      word_out
);

   logic [2:0]            sclk_sync_reg;
   logic [1:0]            data_sync_reg;
   logic [2:0]            le_sync_reg;
   logic [PSC_WORD_W-1:0] shift_reg;
   psc_word_type          word_reg;

   wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   wire le_rise   = le_sync_reg[1] & ~le_sync_reg[2];

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_sync_reg <= 3'h0;
         data_sync_reg <= 2'h0;
         le_sync_reg   <= 3'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], ser_clk};
         data_sync_reg <= {data_sync_reg[0], ser_data};
         le_sync_reg   <= {le_sync_reg[1:0], load_en};
      end
   end

   // msb first, so the first bit ends at the top; never gated by power-down
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= PSC_WORD_RESET;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[PSC_WORD_W-2:0], data_sync_reg[1]};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_reg <= '0;
      end else begin
         word_reg.valid <= le_rise;
         word_reg.word  <= le_rise ? shift_reg : word_reg.word;
      end
   end

   assign word_out = word_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking rx_cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   shift_in_a: assert property (sclk_rise |=> shift_reg[0] == $past(data_sync_reg[1]))
      else $error("serial bit not shifted in");
   load_word_a: assert property (le_rise |=> word_out.valid && word_out.word == $past(shift_reg))
      else $error("loaded word differs from shift register");

endmodule

// ===== hdl/psc_pll_control.sv
/*
 * Control latches of a PLL synthesizer: latch decode, counter hold, power-down
 * modes with chip enable, fastlock timer, pump current select, internal reset.
 * Assumes PUMP_EVENT is a one-cycle pulse on CLK from the phase detector path
 * and that the serial pins and chip enable are asynchronous to CLK.
 */
`timescale 1ns/1ps
// Summary of operation
// - select bits 11 store initialization latch
// - select bits 10 store function latch
// - counter hold bit holds all counters reset
// - counters released together, aligned
// - chip enable low powers down regardless
// - request without sync select: immediate power-down
// - request with sync select: wait pump event
// - power-down loads counters, tristates pump, clears lock
// - serial register keeps working in power-down
// - fastlock timeout only when fastlock enable set
// - mode bit: zero mode 1, one mode 2
// - mode 1: boost bit selects secondary current
// - mode 2: timeout clears boost bit
// - timeout counter runs only in mode 2
// - primary and secondary currents from two fields
// - three-state bit floats pump output
// - initialization load fires internal reset pulse
// - initialization pulse triggers programmed sync power-down
// - first AB load after init pulses again
// - select 00 reference latch, 01 AB latch
// - counter hold never invokes sync power-down
module psc_pll_control
   import psc_pkg::*;
#(
   parameter int FL_UNIT_EVENTS = PSC_FL_UNIT_EVENTS,
   parameter int TMR_W          = PSC_TMR_W
) (
   input  wire logic                  CLK,
   input  wire logic                  RESET_N,
   input  wire logic                  SER_CLK,
   input  wire logic                  SER_DATA,
   input  wire logic                  LOAD_EN,
   input  wire logic                  CHIP_ENABLE,
   input  wire logic                  PUMP_EVENT,
   output logic                       POWER_DOWN,
   output logic                       COUNTER_LOAD,
   output logic                       PUMP_HIGH_Z,
   output logic                       LOCK_DETECT_CLEAR,
   output logic [2:0]                 PUMP_CURRENT,
   output logic                       FASTLOCK_ACTIVE,
   output logic [2:0]                 MONITOR_SELECT,
   output logic [1:0]                 PRESCALER_SELECT,
   output logic                       PD_POLARITY,
   output logic [PSC_WORD_W-1:0]      REF_LATCH_WORD,
   output logic [PSC_WORD_W-1:0]      AB_LATCH_WORD
);

   logic [1:0]            rst_sync_reg;
   logic [1:0]            ce_sync_reg;
   psc_word_type          rx_word;
   psc_func_type          func_reg;
   psc_func_type          func_next;
   logic [PSC_WORD_W-1:0] ref_reg;
   logic [PSC_WORD_W-1:0] ab_reg;
   logic                  gain_next;
   logic                  first_ab_reg;
   logic                  int_pulse_reg;
   logic [TMR_W-1:0]      tmr_reg;
   logic [TMR_W-1:0]      tmr_next;
   psc_pd_state_type      pd_state_reg;
   psc_pd_state_type      pd_state_next;
   logic                  counter_load_reg;
   logic                  pump_high_z_reg;
   logic                  lock_clear_reg;
   logic [2:0]            pump_current_reg;
   logic                  fastlock_active_reg;
   logic                  live_reg;

   wire rst_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // reset release and chip enable synchronisers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_sync_reg <= PSC_SYNC_RESET;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ce_sync_reg <= PSC_SYNC_RESET;
      end else begin
         ce_sync_reg <= {ce_sync_reg[0], CHIP_ENABLE};
      end
   end

   wire ce_high = ce_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // serial receiver runs in every power state
   psc_serial_rx u_rx (
      .clk      (CLK),
      .rst_n    (rst_n),
      .ser_clk  (SER_CLK),
      .ser_data (SER_DATA),
      .load_en  (LOAD_EN),
      .word_out (rx_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // latch decode
   wire [1:0] sel     = rx_word.word[1:0];
   wire       ld_ref  = rx_word.valid && (sel == PSC_SEL_REF);
   wire       ld_ab   = rx_word.valid && (sel == PSC_SEL_AB);
   wire       ld_func = rx_word.valid && (sel == PSC_SEL_FUNC);
   wire       ld_init = rx_word.valid && (sel == PSC_SEL_INIT);

   assign func_next = (ld_func || ld_init) ? psc_func_type'(rx_word.word) : func_reg;

   ////////////////////////////////////////////////////////////////////////////
   // fastlock: mode 2 counts pump events, mode 1 and disabled leave boost alone
   wire gain     = ab_reg[PSC_AB_GAIN_POS];
   wire fl_mode2 = func_reg.fastlock_enable && func_reg.fastlock_mode;
   // top bit is set only in PSC_DOWN, so the power-down pin comes from a flop
   wire pd_down  = pd_state_reg[1];
   wire fl_run   = fl_mode2 && gain && !pd_down && !int_pulse_reg;

   wire [TMR_W-1:0] tmr_limit =
      TMR_W'(({1'b0, func_reg.fastlock_timeout_select} + 5'h01) * FL_UNIT_EVENTS);
   wire fl_expire = fl_run && PUMP_EVENT && (tmr_reg == tmr_limit - TMR_W'(1));

   // a new AB load wins over an expiry in the same cycle and restarts the timer
   assign gain_next = ld_ab ? rx_word.word[PSC_AB_GAIN_POS] :
                      (fl_expire ? 1'b0 : gain);

   always_comb begin
      tmr_next = tmr_reg;
      if (!fl_run || ld_ab || fl_expire) begin
         tmr_next = PSC_TMR_RESET;
      end else if (PUMP_EVENT) begin
         tmr_next = tmr_reg + TMR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power-down state
   wire pd_req  = func_reg.power_down_request_bit;
   wire pd_sync = func_reg.power_down_sync_select;

   always_comb begin
      pd_state_next = PSC_RUN;
      if (!ce_high) begin
         pd_state_next = PSC_DOWN;
      end else if (pd_req && !pd_sync) begin
         pd_state_next = PSC_DOWN;
      end else if (pd_req) begin
         unique case (pd_state_reg)
            PSC_DOWN: begin
               pd_state_next = PSC_DOWN;
            end
            PSC_RUN, PSC_SYNC_WAIT: begin
               pd_state_next = (PUMP_EVENT || int_pulse_reg) ? PSC_DOWN : PSC_SYNC_WAIT;
            end
            default: begin
               pd_state_next = PSC_DOWN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         func_reg      <= PSC_FUNC_RESET;
         ref_reg       <= PSC_WORD_RESET;
         ab_reg        <= PSC_WORD_RESET;
         tmr_reg       <= PSC_TMR_RESET;
         pd_state_reg  <= PSC_RUN;
      end else begin
         func_reg      <= func_next;
         ref_reg       <= ld_ref ? rx_word.word : ref_reg;
         ab_reg        <= {ld_ab ? rx_word.word[PSC_WORD_W-1:PSC_AB_GAIN_POS+1]
                                 : ab_reg[PSC_WORD_W-1:PSC_AB_GAIN_POS+1],
                           gain_next,
                           ld_ab ? rx_word.word[PSC_AB_GAIN_POS-1:0]
                                 : ab_reg[PSC_AB_GAIN_POS-1:0]};
         tmr_reg       <= tmr_next;
         pd_state_reg  <= pd_state_next;
      end
   end

   // internal reset pulse: on init load, and once more on the first AB load
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         first_ab_reg  <= 1'b0;
         int_pulse_reg <= 1'b0;
      end else begin
         first_ab_reg  <= ld_init || (first_ab_reg && !ld_ab);
         int_pulse_reg <= ld_init || (ld_ab && first_ab_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one load signal for the R and N counters keeps them released in step;
   // counter hold touches only load and pump, never the power state
   wire hold_w = func_reg.counter_hold_bit;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         counter_load_reg    <= 1'b1;
         pump_high_z_reg     <= 1'b1;
         lock_clear_reg      <= 1'b1;
         pump_current_reg    <= 3'h0;
         fastlock_active_reg <= 1'b0;
      end else begin
         counter_load_reg    <= pd_down || hold_w || int_pulse_reg;
         pump_high_z_reg     <= pd_down || hold_w || int_pulse_reg ||
                                func_reg.pump_three_state;
         lock_clear_reg      <= pd_down;
         pump_current_reg    <= gain ? func_reg.secondary_pump_current
                                     : func_reg.primary_pump_current;
         fastlock_active_reg <= gain;
      end
   end

   assign POWER_DOWN        = pd_down;
   assign COUNTER_LOAD      = counter_load_reg;
   assign PUMP_HIGH_Z       = pump_high_z_reg;
   assign LOCK_DETECT_CLEAR = lock_clear_reg;
   assign PUMP_CURRENT      = pump_current_reg;
   assign FASTLOCK_ACTIVE   = fastlock_active_reg;
   assign MONITOR_SELECT    = func_reg.monitor_mux_select;
   assign PRESCALER_SELECT  = func_reg.prescaler_ratio_select;
   assign PD_POLARITY       = func_reg.pd_polarity;
   assign REF_LATCH_WORD    = ref_reg;
   assign AB_LATCH_WORD     = ab_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks start one edge after rst_n rises: the flops leave reset only then,
   // so an attempt at the release edge would see stale reset values
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         live_reg <= 1'b0;
      end else begin
         live_reg <= 1'b1;
      end
   end

   default clocking ctl_cb @(posedge CLK);
   endclocking
   default disable iff (!live_reg);

   sequence init_pulse_s;
      ##1 int_pulse_reg ##1 (COUNTER_LOAD && PUMP_HIGH_Z);
   endsequence

   sequence expire_s;
      ##1 !AB_LATCH_WORD[PSC_AB_GAIN_POS] ##1 (PUMP_CURRENT == func_reg.primary_pump_current);
   endsequence

   ce_down_a: assert property (!ce_high |=> POWER_DOWN)
      else $error("chip enable low did not power down");
   async_pd_a: assert property (ce_high && pd_req && !pd_sync |=> POWER_DOWN)
      else $error("asynchronous power-down not immediate");
   sync_wait_a: assert property (pd_state_reg == PSC_RUN && ce_high && pd_req && pd_sync &&
                                 !PUMP_EVENT && !int_pulse_reg |=> !POWER_DOWN)
      else $error("synchronous power-down did not wait for pump event");
   pd_effects_a: assert property (POWER_DOWN |=> COUNTER_LOAD && PUMP_HIGH_Z &&
                                  LOCK_DETECT_CLEAR && tmr_reg == PSC_TMR_RESET)
      else $error("power-down side effects missing");
   init_pulse_a: assert property (ld_init |-> init_pulse_s)
      else $error("initialization load gave no reset pulse");
   late_ab_a: assert property (ld_ab && !first_ab_reg |=> !int_pulse_reg)
      else $error("later AB load fired reset pulse");
   fl_expire_a: assert property (fl_expire && !ld_ab |-> expire_s)
      else $error("timeout did not clear boost");
   timer_idle_a: assert property (!fl_mode2 |=> tmr_reg == PSC_TMR_RESET)
      else $error("timeout counter ran outside mode 2");
   hold_a: assert property (hold_w && ce_high && !pd_req |=>
                            COUNTER_LOAD && PUMP_HIGH_Z && !POWER_DOWN)
      else $error("counter hold misbehaved");
   first_ab_a: assert property (ld_ab && first_ab_reg |-> init_pulse_s)
      else $error("first AB load after init gave no reset pulse");
   three_state_a: assert property (func_reg.pump_three_state |=> PUMP_HIGH_Z)
      else $error("three-state bit did not float the pump");
   pump_driven_a: assert property (!func_reg.pump_three_state && !pd_down &&
                                   !hold_w && !int_pulse_reg |=> !PUMP_HIGH_Z)
      else $error("pump left floating while it should drive");
   boost_current_a: assert property (gain |=>
                                     PUMP_CURRENT == $past(func_reg.secondary_pump_current))
      else $error("boost set but pump not on secondary current");
   primary_current_a: assert property (!gain |=>
                                       PUMP_CURRENT == $past(func_reg.primary_pump_current))
      else $error("boost clear but pump not on primary current");
   ref_store_a: assert property (ld_ref |=> REF_LATCH_WORD == $past(rx_word.word))
      else $error("reference word not stored");
   func_store_a: assert property (ld_func || ld_init |=>
                                  func_reg == $past(rx_word.word))
      else $error("function or initialization word not stored");
   boost_hold_a: assert property (gain && !fl_mode2 && !ld_ab |=>
                                  AB_LATCH_WORD[PSC_AB_GAIN_POS])
      else $error("boost bit cleared outside mode 2");
   hold_release_a: assert property (!hold_w && !pd_down && !int_pulse_reg |=>
                                    !COUNTER_LOAD)
      else $error("counters not released together");
   init_sync_pd_a: assert property (int_pulse_reg && ce_high && pd_req && pd_sync |=>
                                    POWER_DOWN)
      else $error("reset pulse did not trigger synchronous power-down");
   lock_clear_a: assert property (!pd_down |=> !LOCK_DETECT_CLEAR)
      else $error("lock detect cleared while running");

endmodule

// ===== bench/psc_host_model.sv
/*
 * Host side of the three-wire serial link: shifts 24-bit words out msb first,
 * then strobes the load line. Assumes the receiver samples on its own clock.
 */
`timescale 1ns/1ps
module psc_host_model (
   output logic ser_clk,
   output logic ser_data,
   output logic load_en
);

   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      load_en = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // link clock toggles only inside a frame; odd offset keeps it off CLK phase
   task automatic send_word(input logic [23:0] w);
      #7;
      for (int i = 23; i >= 0; i--) begin
         ser_data = w[i];
         #160 ser_clk = 1'b1;
         #160 ser_clk = 1'b0;
      end
      // released data line must not keep showing the last bit
      ser_data = ~w[0];
      #160 load_en = 1'b1;
      #160 load_en = 1'b0;
   endtask

endmodule

// ===== bench/testbench.sv
/*
 * Self-checking bench of the synthesizer control latches.
 * Assumes the host model drives the serial pins; cycle relations are
 * guarded by the assertions inside the design.
 */
`timescale 1ns/1ps
module testbench
   import psc_pkg::*;
;
   logic        clk, reset_n, chip_enable, pump_event;
   logic        ser_clk, ser_data, load_en;
   logic        power_down, counter_load, pump_high_z, lock_clear, fastlock_active;
   logic [2:0]  pump_current, monitor_select;
   logic [1:0]  prescaler_select;
   logic        pd_polarity;
   logic [23:0] ref_word, ab_word;
   int          fail_count = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          pulse_cnt = 0;

   psc_pll_control #(.FL_UNIT_EVENTS(4), .TMR_W(8)) i_psc_pll_control (
      .CLK(clk), .RESET_N(reset_n), .SER_CLK(ser_clk), .SER_DATA(ser_data),
      .LOAD_EN(load_en), .CHIP_ENABLE(chip_enable), .PUMP_EVENT(pump_event),
      .POWER_DOWN(power_down), .COUNTER_LOAD(counter_load),
      .PUMP_HIGH_Z(pump_high_z), .LOCK_DETECT_CLEAR(lock_clear),
      .PUMP_CURRENT(pump_current), .FASTLOCK_ACTIVE(fastlock_active),
      .MONITOR_SELECT(monitor_select), .PRESCALER_SELECT(prescaler_select),
      .PD_POLARITY(pd_polarity), .REF_LATCH_WORD(ref_word), .AB_LATCH_WORD(ab_word)
   );

   psc_host_model i_psc_host_model (
      .ser_clk(ser_clk), .ser_data(ser_data), .load_en(load_en)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // counts cycles with the counters held, to see internal reset pulses
   always @(posedge clk) begin
      cycles++;
      if (counter_load === 1'b1) pulse_cnt++;
      if (cycles == 30000) begin
         fail_count++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic ld(input logic [23:0] w);
      i_psc_host_model.send_word(w);
      repeat (4) @(negedge clk);
   endtask

   task automatic pump(input int n);
      repeat (n) begin
         @(negedge clk) pump_event = 1'b1;
         @(negedge clk) pump_event = 1'b0;
      end
   endtask

   // prescaler fixed at a ratio the host considers safe for its rf input
   function automatic logic [23:0] fw(input logic [1:0] sel, input logic hold, pd, sync,
                                      tri_s, flen, mode, input logic [3:0] tmo,
                                      input logic [2:0] pri, sec);
      return {2'h2, sync, sec, pri, tmo, mode, flen, tri_s, 1'b0, 3'h0, pd, hold, sel};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_ref_ab();
      ld({22'h2a5c31, PSC_SEL_REF});
      chk(ref_word, {22'h2a5c31, PSC_SEL_REF});
      ld({22'h05a3ce, PSC_SEL_AB});
      chk(ab_word, {22'h05a3ce, PSC_SEL_AB});
      $display("ref_ab finished");
   endtask

   task automatic t_func();
      ld(fw(PSC_SEL_FUNC, 0, 0, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6) | 24'h0000d0);
      chk(monitor_select, 3'h5);
      chk({pd_polarity, prescaler_select}, 3'h6);
      chk(pump_current, 3'h3);
      ld({22'h080000, PSC_SEL_AB});
      chk(pump_current, 3'h6);
      chk(fastlock_active, 1'b1);
      ld(fw(PSC_SEL_FUNC, 0, 0, 0, 1, 0, 0, 4'h0, 3'h3, 3'h6));
      chk(pump_high_z, 1'b1);
      ld(fw(PSC_SEL_FUNC, 0, 0, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      chk(pump_high_z, 1'b0);
      ld({22'h000000, PSC_SEL_AB});
      chk(pump_current, 3'h3);
      $display("func finished");
   endtask

   task automatic t_hold();
      ld(fw(PSC_SEL_FUNC, 1, 0, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      chk(counter_load, 1'b1);
      chk({pump_high_z, power_down}, 2'h2);
      ld(fw(PSC_SEL_FUNC, 0, 0, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      chk(counter_load, 1'b0);
      $display("hold finished");
   endtask

   task automatic t_ce();
      @(negedge clk) chip_enable = 1'b0;
      repeat (5) @(negedge clk);
      chk(power_down, 1'b1);
      chk({counter_load, pump_high_z, lock_clear}, 3'h7);
      ld({22'h1c0f0f, PSC_SEL_REF});
      chk(ref_word, {22'h1c0f0f, PSC_SEL_REF});
      @(negedge clk) chip_enable = 1'b1;
      repeat (5) @(negedge clk);
      chk(power_down, 1'b0);
      $display("ce finished");
   endtask

   task automatic t_pd();
      ld(fw(PSC_SEL_FUNC, 0, 1, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      chk(power_down, 1'b1);
      chk(lock_clear, 1'b1);
      ld(fw(PSC_SEL_FUNC, 0, 0, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      ld(fw(PSC_SEL_FUNC, 0, 1, 1, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      repeat (20) @(negedge clk);
      chk(power_down, 1'b0);
      pump(1);
      repeat (2) @(negedge clk);
      chk(power_down, 1'b1);
      ld(fw(PSC_SEL_FUNC, 0, 0, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      chk(power_down, 1'b0);
      $display("pd finished");
   endtask

   task automatic t_init();
      ld(fw(PSC_SEL_INIT, 0, 1, 1, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      chk(power_down, 1'b1);
      ld(fw(PSC_SEL_FUNC, 0, 0, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6));
      ld({22'h000000, PSC_SEL_AB});
      pulse_cnt = 0;
      ld(fw(PSC_SEL_INIT, 0, 0, 0, 0, 0, 0, 4'h0, 3'h3, 3'h6) | 24'h000030);
      chk(pulse_cnt, 24'h000001);
      chk(monitor_select, 3'h3);
      pulse_cnt = 0;
      ld({22'h001234, PSC_SEL_AB});
      chk(pulse_cnt, 24'h000001);
      pulse_cnt = 0;
      ld({22'h004321, PSC_SEL_AB});
      chk(pulse_cnt, 24'h000000);
      $display("init finished");
   endtask

   task automatic t_fast();
      ld(fw(PSC_SEL_FUNC, 0, 0, 0, 0, 1, 1, 4'h1, 3'h2, 3'h5));
      ld({22'h080000, PSC_SEL_AB});
      chk(pump_current, 3'h5);
      pump(7);
      chk(pump_current, 3'h5);
      pump(1);
      repeat (3) @(negedge clk);
      chk({ab_word[21], pump_current}, 4'h2);
      chk(fastlock_active, 1'b0);
      for (int k = 0; k < 2; k++) begin
         ld(fw(PSC_SEL_FUNC, 0, 0, 0, 0, ~k[0], k[0], 4'h0, 3'h2, 3'h5));
         ld({22'h080000, PSC_SEL_AB});
         pump(12);
         repeat (3) @(negedge clk);
         chk({ab_word[21], pump_current}, 4'hd);
         ld({22'h000000, PSC_SEL_AB});
         chk(pump_current, 3'h2);
      end
      $display("fast finished");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      chip_enable = 1'b1;
      pump_event = 1'b0;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      repeat (10) @(negedge clk);
      t_ref_ab();
      t_func();
      t_hold();
      t_ce();
      t_pd();
      t_init();
      t_fast();
      end_sim();
   end

endmodule
